// File: dtc_map.vh
// Register map, field positions, reset values and timing counts of the dual timer/counter.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTC_OFS_CTRL    4'h0
`define DTC_OFS_MODE    4'h1
`define DTC_OFS_C0_LO   4'h2
`define DTC_OFS_C0_HI   4'h3
`define DTC_OFS_C1_LO   4'h4
`define DTC_OFS_C1_HI   4'h5
`define DTC_OFS_STAT    4'h6
`define DTC_OFS_MASK    4'h7

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DTC_CTL_C1_OVF  7
`define DTC_CTL_C1_RUN  6
`define DTC_CTL_C0_OVF  5
`define DTC_CTL_C0_RUN  4
`define DTC_CTL_X1_FLAG 3
`define DTC_CTL_X1_TYPE 2
`define DTC_CTL_X0_FLAG 1
`define DTC_CTL_X0_TYPE 0

// ----------------------------------------
// Mode register fields, per nibble
// ----------------------------------------
`define DTC_MOD_GATE    3
`define DTC_MOD_CT      2
`define DTC_MOD_C1_LSB  4
`define DTC_MOD_C0_LSB  0
`define DTC_MODE_PRE    2'h0
`define DTC_MODE_16     2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT  2'h3

// ----------------------------------------
// Status and mask bits
// ----------------------------------------
`define DTC_ST_C0_OVF   0
`define DTC_ST_C1_OVF   1
`define DTC_ST_X0       2
`define DTC_ST_X1       3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DTC_RST_BYTE    8'h00
`define DTC_RST_STAT    4'h0
`define DTC_MC_DIV      12
`define DTC_PRE_MAX     5'h1F

`endif

// File: dtc_sync.v
// Two-flop synchroniser with edge detection for the asynchronous pins.
// Assumes the pins are unrelated to ref_clk; the first flop feeds no logic.
module dtc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst_b,
  // Pins and conditioned views
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] lvl,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // Idle high so no false falling edge appears after reset
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
      prev_q <= {W{1'b1}};
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lvl  = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// File: dtc_counter.v
// One 16-bit timer/counter held as a low and a high byte, with four modes.
// Assumes count enables are one-cycle pulses on ref_clk; software writes win.
`include "dtc_map.vh"
module dtc_counter (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // Count control
  input  wire       cnt_en,
  input  wire       hi_en,
  input  wire [1:0] mode,
  // Software access
  input  wire       wr_lo,
  input  wire       wr_hi,
  input  wire [7:0] wdata,
  output reg  [7:0] lo_q,
  output reg  [7:0] hi_q,
  // Overflow pulses
  output reg        ovf,
  output reg        ovf_hi
);

  reg [7:0] lo_d;
  reg [7:0] hi_d;

  function [7:0] inc8;
    input [7:0] v;
    begin
      inc8 = v + 8'h01;
    end
  endfunction

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always @* begin
    lo_d   = lo_q;
    hi_d   = hi_q;
    ovf    = 1'b0;
    ovf_hi = 1'b0;
    if (cnt_en) begin
      case (mode)
        `DTC_MODE_PRE: begin
          // Low five bits are the divide-by-32 prescaler
          if (lo_q[4:0] == `DTC_PRE_MAX) begin
            lo_d[4:0] = 5'h00;
            hi_d      = inc8(hi_q);
            ovf       = (hi_q == 8'hFF);
          end else begin
            lo_d[4:0] = lo_q[4:0] + 5'h01;
          end
        end
        `DTC_MODE_16: begin
          lo_d = inc8(lo_q);
          if (lo_q == 8'hFF) begin
            hi_d = inc8(hi_q);
            ovf  = (hi_q == 8'hFF);
          end
        end
        `DTC_MODE_RELOAD: begin
          if (lo_q == 8'hFF) begin
            lo_d = hi_q;
            ovf  = 1'b1;
          end else begin
            lo_d = inc8(lo_q);
          end
        end
        default: begin
          lo_d = inc8(lo_q);
          ovf  = (lo_q == 8'hFF);
        end
      endcase
    end
    if (hi_en && mode == `DTC_MODE_SPLIT) begin
      hi_d   = inc8(hi_q);
      ovf_hi = (hi_q == 8'hFF);
    end
    if (wr_lo) begin
      lo_d = wdata;
    end
    if (wr_hi) begin
      hi_d = wdata;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_q <= `DTC_RST_BYTE;
      hi_q <= `DTC_RST_BYTE;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

endmodule

// File: dtc_top.v
// Dual 16-bit timer/counter with external interrupt flags and a register port.
// Assumes a core on ref_clk that strobes registers and pulses vector acknowledges.
//
// Our own choices: the placing of the registers and strobed register access.
`include "dtc_map.vh"

module dtc_top #(
  parameter MC_DIV = `DTC_MC_DIV
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Pins
  input  wire       ext_irq0_pin,
  input  wire       ext_irq1_pin,
  input  wire       count0_pin,
  input  wire       count1_pin,
  // Vector acknowledges from the core
  input  wire       vec_ack_c0,
  input  wire       vec_ack_c1,
  input  wire       vec_ack_x0,
  input  wire       vec_ack_x1,
  // Requests to the core
  output reg        counter0_ovf_req,
  output reg        counter1_ovf_req,
  output reg        ext_irq0_req,
  output reg        ext_irq1_req,
  output reg        irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [7:0] ctrl_q;
  reg  [7:0] ctrl_d;
  reg  [7:0] mode_q;
  reg  [3:0] stat_q;
  reg  [3:0] stat_d;
  reg  [3:0] mask_q;
  reg  [7:0] mc_cnt_q;
  reg        mc_tick_q;
  reg  [7:0] rd_mux;
  reg  [3:0] ev;

  wire [3:0] pin_lvl;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;
  wire [7:0] c0_lo;
  wire [7:0] c0_hi;
  wire [7:0] c1_lo;
  wire [7:0] c1_hi;
  wire       c0_ovf;
  wire       c0_ovf_hi;
  wire       c1_ovf;

  wire [3:0] c0_cfg = mode_q[`DTC_MOD_C0_LSB +: 4];
  wire [3:0] c1_cfg = mode_q[`DTC_MOD_C1_LSB +: 4];
  wire [1:0] c0_mode = c0_cfg[1:0];
  wire [1:0] c1_mode = c1_cfg[1:0];
  wire       c0_run = ctrl_q[`DTC_CTL_C0_RUN];
  wire       c1_run = ctrl_q[`DTC_CTL_C1_RUN];
  wire       x0_type = ctrl_q[`DTC_CTL_X0_TYPE];
  wire       x1_type = ctrl_q[`DTC_CTL_X1_TYPE];

  wire       wr_ctrl = reg_wr && reg_addr == `DTC_OFS_CTRL;
  wire       wr_mode = reg_wr && reg_addr == `DTC_OFS_MODE;
  wire       wr_stat = reg_wr && reg_addr == `DTC_OFS_STAT;
  wire       wr_mask = reg_wr && reg_addr == `DTC_OFS_MASK;

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  // Bits: 0 irq0, 1 irq1, 2 count0, 3 count1
  dtc_sync #(
    .W (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  ({count1_pin, count0_pin, ext_irq1_pin, ext_irq0_pin}),
    .lvl     (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ----------------------------------------
  // Machine cycle divider
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mc_cnt_q  <= 8'h00;
      mc_tick_q <= 1'b0;
    end else if (mc_cnt_q == MC_DIV[7:0] - 8'h01) begin
      mc_cnt_q  <= 8'h00;
      mc_tick_q <= 1'b1;
    end else begin
      mc_cnt_q  <= mc_cnt_q + 8'h01;
      mc_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Count enables
  // ----------------------------------------
  function count_enable;
    input       run;
    input [3:0] cfg;
    input       gate_pin;
    input       mc_tick;
    input       pin_fall_ev;
    reg         tick;
    begin
      tick = cfg[`DTC_MOD_CT] ? pin_fall_ev : mc_tick;
      count_enable = run && (!cfg[`DTC_MOD_GATE] || gate_pin) && tick;
    end
  endfunction

  // Gate bit and selector sit in each nibble of the mode register
  wire c0_en = count_enable(c0_run, c0_cfg, pin_lvl[0], mc_tick_q, pin_fall[2]);
  wire c1_en = count_enable(c1_run, c1_cfg, pin_lvl[1], mc_tick_q, pin_fall[3])
               && c1_mode != `DTC_MODE_SPLIT;
  // In split mode the upper half of counter 0 borrows counter 1 run bit
  wire c0_hi_en = c1_run && mc_tick_q;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  dtc_counter u_c0 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .cnt_en  (c0_en),
    .hi_en   (c0_hi_en),
    .mode    (c0_mode),
    .wr_lo   (reg_wr && reg_addr == `DTC_OFS_C0_LO),
    .wr_hi   (reg_wr && reg_addr == `DTC_OFS_C0_HI),
    .wdata   (reg_wdata),
    .lo_q    (c0_lo),
    .hi_q    (c0_hi),
    .ovf     (c0_ovf),
    .ovf_hi  (c0_ovf_hi)
  );

  dtc_counter u_c1 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .cnt_en  (c1_en),
    .hi_en   (1'b0),
    .mode    (c1_mode),
    .wr_lo   (reg_wr && reg_addr == `DTC_OFS_C1_LO),
    .wr_hi   (reg_wr && reg_addr == `DTC_OFS_C1_HI),
    .wdata   (reg_wdata),
    .lo_q    (c1_lo),
    .hi_q    (c1_hi),
    .ovf     (c1_ovf),
    .ovf_hi  ()
  );

  // ----------------------------------------
  // Hardware events
  // ----------------------------------------
  always @* begin
    ev = 4'h0;
    ev[`DTC_ST_C0_OVF] = c0_ovf;
    // Split counter 0 takes over the counter 1 flag
    ev[`DTC_ST_C1_OVF] = (c0_mode == `DTC_MODE_SPLIT) ? c0_ovf_hi : c1_ovf;
    ev[`DTC_ST_X0] = !x0_type && pin_fall[0];
    ev[`DTC_ST_X1] = !x1_type && (pin_rise[1] || pin_fall[1]);
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Software write, then vector clear, then hardware set: set wins
  always @* begin
    ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;
    if (vec_ack_c0) begin
      ctrl_d[`DTC_CTL_C0_OVF] = 1'b0;
    end
    if (vec_ack_c1) begin
      ctrl_d[`DTC_CTL_C1_OVF] = 1'b0;
    end
    if (vec_ack_x0) begin
      ctrl_d[`DTC_CTL_X0_FLAG] = 1'b0;
    end
    if (vec_ack_x1) begin
      ctrl_d[`DTC_CTL_X1_FLAG] = 1'b0;
    end
    if (ev[`DTC_ST_C0_OVF]) begin
      ctrl_d[`DTC_CTL_C0_OVF] = 1'b1;
    end
    if (ev[`DTC_ST_C1_OVF]) begin
      ctrl_d[`DTC_CTL_C1_OVF] = 1'b1;
    end
    if (ev[`DTC_ST_X0]) begin
      ctrl_d[`DTC_CTL_X0_FLAG] = 1'b1;
    end
    if (ev[`DTC_ST_X1]) begin
      ctrl_d[`DTC_CTL_X1_FLAG] = 1'b1;
    end
  end

  // ----------------------------------------
  // Interrupt status, write one to clear
  // ----------------------------------------
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~reg_wdata[3:0];
    end
    stat_d = stat_d | ev;
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `DTC_RST_BYTE;
      mode_q <= `DTC_RST_BYTE;
      stat_q <= `DTC_RST_STAT;
      mask_q <= `DTC_RST_STAT;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      if (wr_mode) begin
        mode_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `DTC_OFS_CTRL:  rd_mux = ctrl_q;
      `DTC_OFS_MODE:  rd_mux = mode_q;
      `DTC_OFS_C0_LO: rd_mux = c0_lo;
      `DTC_OFS_C0_HI: rd_mux = c0_hi;
      `DTC_OFS_C1_LO: rd_mux = c1_lo;
      `DTC_OFS_C1_HI: rd_mux = c1_hi;
      `DTC_OFS_STAT:  rd_mux = {4'h0, stat_q};
      `DTC_OFS_MASK:  rd_mux = {4'h0, mask_q};
      default:        rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Requests to the core
  // ----------------------------------------
  // Level mode follows the synchronised pin, so a long low keeps requesting
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter0_ovf_req <= 1'b0;
      counter1_ovf_req <= 1'b0;
      ext_irq0_req     <= 1'b0;
      ext_irq1_req     <= 1'b0;
      irq              <= 1'b0;
    end else begin
      counter0_ovf_req <= ctrl_d[`DTC_CTL_C0_OVF];
      counter1_ovf_req <= ctrl_d[`DTC_CTL_C1_OVF];
      ext_irq0_req     <= x0_type ? !pin_lvl[0] : ctrl_d[`DTC_CTL_X0_FLAG];
      ext_irq1_req     <= x1_type ? !pin_lvl[1] : ctrl_d[`DTC_CTL_X1_FLAG];
      irq              <= |(stat_d & mask_q);
    end
  end

endmodule

// File: dtc_top_chk.sv
// Port assertions for the dual timer/counter.
// Assumes run and type bits change only by register writes.
`include "dtc_map.vh"
module dtc_chk (
  // Clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Pins and acknowledges
  input wire       ext_irq0_pin,
  input wire       ext_irq1_pin,
  input wire       count0_pin,
  input wire       count1_pin,
  input wire       vec_ack_c0,
  input wire       vec_ack_c1,
  input wire       vec_ack_x0,
  input wire       vec_ack_x1,
  // Requests
  input wire       counter0_ovf_req,
  input wire       counter1_ovf_req,
  input wire       ext_irq0_req,
  input wire       ext_irq1_req,
  input wire       irq
);
  // ---
  // Software-owned bits, mirrored from writes
  // ---
  reg [7:0] ctl_q;
  reg [3:0] msk_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= 8'h00;
      msk_q <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == `DTC_OFS_CTRL) ctl_q <= reg_wdata;
      if (reg_addr == `DTC_OFS_MASK) msk_q <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_hole;
    reg_rd && reg_addr[3] |=> reg_rdata == 8'h00;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  // Run off, so no fresh overflow can outrun the clear
  property p_c0_ack;
    vec_ack_c0 && !reg_wr && !ctl_q[`DTC_CTL_C0_RUN] |-> ##2 !counter0_ovf_req;
  endproperty
  a_c0_ack: assert property (p_c0_ack) else $error("counter0 flag kept");
  property p_c1_ack;
    vec_ack_c1 && !reg_wr && !ctl_q[`DTC_CTL_C1_RUN] |-> ##2 !counter1_ovf_req;
  endproperty
  a_c1_ack: assert property (p_c1_ack) else $error("counter1 flag kept");
  property p_x0_fall;
    $fell(ext_irq0_pin) && !ctl_q[0] |-> ##[1:6] ext_irq0_req;
  endproperty
  a_x0_fall: assert property (p_x0_fall) else $error("irq0 edge missed");
  property p_x1_edge;
    $changed(ext_irq1_pin) && !ctl_q[2] |-> ##[1:6] ext_irq1_req;
  endproperty
  a_x1_edge: assert property (p_x1_edge) else $error("irq1 edge missed");
  property p_x0_lvl;
    (ctl_q[0] && !ext_irq0_pin)[*4] |=> ext_irq0_req;
  endproperty
  a_x0_lvl: assert property (p_x0_lvl) else $error("irq0 level missed");
  property p_x1_lvl;
    (ctl_q[2] && !ext_irq1_pin)[*4] |=> ext_irq1_req;
  endproperty
  a_x1_lvl: assert property (p_x1_lvl) else $error("irq1 level missed");
  property p_msk;
    (msk_q == 4'h0)[*3] |-> !irq;
  endproperty
  a_msk: assert property (p_msk) else $error("masked interrupt raised");
  c_x0: cover property (ext_irq0_req);
  c_ovf1: cover property (counter1_ovf_req);
  c_irq: cover property (irq && msk_q != 4'h0);
endmodule

bind dtc_top dtc_chk u_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ext_irq0_pin, .ext_irq1_pin, .count0_pin, .count1_pin, .vec_ack_c0,
  .vec_ack_c1, .vec_ack_x0, .vec_ack_x1, .counter0_ovf_req, .counter1_ovf_req,
  .ext_irq0_req, .ext_irq1_req, .irq);

// File: dtc_core_model.sv
// Core vectoring model: one acknowledge pulse per pending request.
// Assumes requests are levels on ref_clk; bench sets en and dly.
module dtc_core_model (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // Bench control, dly of 2 or more avoids a double vector
  input  wire       en,
  input  wire [3:0] dly,
  // Order: c0, c1, x0, x1
  input  wire [3:0] req,
  output reg  [3:0] ack
);
  reg [3:0] wait_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 4'h0;
      ack    <= 4'h0;
    end else begin
      ack <= 4'h0;
      if (!en || req == 4'h0 || ack != 4'h0) begin
        wait_q <= 4'h0;
      end else if (wait_q >= dly) begin
        ack    <= req & (~req + 4'h1);
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// File: dual_timer_counter_bench.sv
// Bench: registers, counting modes and interrupt flags against a model.
// Assumes dtc_top, the core model and the checker are compiled first.
`include "dtc_map.vh"
module dual_timer_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg        ref_clk   = 1'b0;
  reg        rst_b     = 1'b0;
  reg  [3:0] reg_addr  = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr    = 1'b0;
  reg        reg_rd    = 1'b0;
  reg  [1:0] xpin      = 2'h3;
  reg  [1:0] cpin      = 2'h3;
  reg        core_en   = 1'b0;
  reg  [3:0] core_dly  = 4'h2;
  reg  [7:0] d;
  wire [7:0] reg_rdata;
  wire [3:0] req;
  wire [3:0] ack;
  wire       irq;
  int        n_fail    = 0;
  int        compares  = 0;
  int        r0;
  dtc_top #(.MC_DIV(2)) dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq0_pin(xpin[0]), .ext_irq1_pin(xpin[1]), .count0_pin(cpin[0]),
    .count1_pin(cpin[1]), .vec_ack_c0(ack[0]), .vec_ack_c1(ack[1]), .vec_ack_x0(ack[2]),
    .vec_ack_x1(ack[3]), .counter0_ovf_req(req[0]), .counter1_ovf_req(req[1]),
    .ext_irq0_req(req[2]), .ext_irq1_req(req[3]), .irq);
  dtc_core_model u_core (.ref_clk, .rst_b, .en(core_en), .dly(core_dly), .req, .ack);
  always #2 ref_clk = ~ref_clk;
  // ---
  // Tasks
  // ---
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      cpin[ch] <= 1'b0;
      cyc(3);
      cpin[ch] <= 1'b1;
      cyc(2);
    end
  endtask
  // Reference counter, n counted events
  function automatic [16:0] mdl(input int ch, m, l, h, n);
    int o;
    o = 0;
    repeat (n) begin
      case (m)
        0: begin
          l = (l & 224) | ((l + 1) & 31);
          if ((l & 31) == 0) h = (h + 1) & 255;
          if ((l & 31) == 0 && h == 0) o = 1;
        end
        1: begin
          l = (l + 1) & 255;
          if (l == 0) h = (h + 1) & 255;
          if (l == 0 && h == 0) o = 1;
        end
        2: begin
          if (l == 255) o = 1;
          l = (l == 255) ? h : l + 1;
        end
        default: begin
          // Counter 1 stopped, counter 0 low byte alone
          if (ch == 0) l = (l + 1) & 255;
          if (ch == 0 && l == 0) o = 1;
        end
      endcase
    end
    return {o[0], h[7:0], l[7:0]};
  endfunction
  task run_case(input int ch, input int m);
    int lo, hi, n, g, p, r;
    reg [3:0] la;
    reg [7:0] k;
    lo = ($urandom & 255) | 252;
    hi = ($urandom & 255) | 248;
    n  = 1 + $urandom % 6;
    g  = $urandom % 2;
    p  = $urandom % 2;
    la = 4'(`DTC_OFS_C0_LO + 2 * ch);
    k  = (m == 0) ? 8'h1F : 8'hFF;
    r  = mdl(ch, m, lo, hi, (g == 1 && p == 0) ? 0 : n);
    wr(`DTC_OFS_CTRL, 8'h00);
    @(posedge ref_clk);
    xpin[ch] <= p[0];
    wr(`DTC_OFS_MODE, 8'((g * 8 + 4 + m) << (4 * ch)));
    wr(la, 8'(lo));
    wr(la + 4'h1, 8'(hi));
    cyc(4);
    wr(`DTC_OFS_CTRL, 8'(16 << (2 * ch)));
    pulse(ch, n);
    cyc(4);
    rd(`DTC_OFS_CTRL);
    cmp("overflow flag", 8'(r[16]), 8'(d[5 + 2 * ch]));
    wr(`DTC_OFS_CTRL, 8'h00);
    pulse(ch, 2);
    rd(la);
    cmp("count low", r[7:0] & k, d & k);
    rd(la + 4'h1);
    cmp("count high", r[15:8], d);
    @(posedge ref_clk);
    xpin[ch] <= 1'b1;
  endtask
  task tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ---
  // Tests
  // ---
  initial begin
    cyc(20000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    r0 = $urandom(11831);
    cyc(10);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      cmp("reset value", 8'h00, d);
    end
    $display("reset test done");
    for (int a = 1; a < 6; a++) begin
      r0 = $urandom & 255;
      wr(4'(a), 8'(r0));
      wr(4'(a + 8), 8'(~r0));
      rd(4'(a));
      cmp("register", 8'(r0), d);
    end
    $display("register test done");
    for (int i = 0; i < 16; i++) run_case(i / 8, i % 4);
    $display("counter test done");
    wr(`DTC_OFS_MODE, 8'h01);
    wr(`DTC_OFS_C0_LO, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h10);
    cyc(40);
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_C0_LO);
    cmp("timer count", 8'h15, d);
    $display("timer test done");
    wr(`DTC_OFS_MODE, 8'h33);
    wr(`DTC_OFS_C0_HI, 8'hFE);
    wr(`DTC_OFS_CTRL, 8'h40);
    cyc(10);
    rd(`DTC_OFS_CTRL);
    cmp("split flags", 8'h80, d & 8'hA0);
    cmp("split requests", 8'h02, 8'(req[1:0]));
    wr(`DTC_OFS_CTRL, 8'h00);
    rd(`DTC_OFS_C0_HI);
    cmp("split high count", 8'h05, d);
    rd(`DTC_OFS_C0_LO);
    cmp("split low held", 8'h15, d);
    $display("split test done");
    wr(`DTC_OFS_MASK, 8'h00);
    wr(`DTC_OFS_STAT, 8'h0F);
    @(posedge ref_clk);
    xpin <= 2'h0;
    cyc(6);
    rd(`DTC_OFS_CTRL);
    cmp("falling flags", 8'h0A, d & 8'h0A);
    cmp("masked irq", 8'h00, 8'(irq));
    wr(`DTC_OFS_MASK, 8'h0F);
    cyc(3);
    cmp("unmasked irq", 8'h01, 8'(irq));
    wr(`DTC_OFS_CTRL, 8'h00);
    xpin <= 2'h3;
    cyc(6);
    rd(`DTC_OFS_CTRL);
    cmp("rising flags", 8'h08, d & 8'h0A);
    wr(`DTC_OFS_STAT, 8'h0F);
    cyc(3);
    cmp("cleared irq", 8'h00, 8'(irq));
    core_dly <= 4'(2 + $urandom % 4);
    core_en  <= 1'b1;
    wr(`DTC_OFS_CTRL, 8'hAA);
    cyc(40);
    rd(`DTC_OFS_CTRL);
    cmp("vectored flags", 8'h00, d);
    core_en <= 1'b0;
    wr(`DTC_OFS_CTRL, 8'h05);
    xpin <= 2'h0;
    cyc(6);
    cmp("level requests", 8'h03, 8'(req[3:2]));
    xpin <= 2'h3;
    cyc(6);
    cmp("level released", 8'h00, 8'(req[3:2]));
    rd(`DTC_OFS_CTRL);
    cmp("level edge flags", 8'h00, d & 8'h0A);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule
